/* File: hw/rimg_consts.svh */
`ifndef RIMG_CONSTS_SVH
`define RIMG_CONSTS_SVH
// ==========================================================
// Register offsets
`define RIMG_OFS_FLAG   8'h00
`define RIMG_OFS_MASK   8'h01
`define RIMG_OFS_GATE   8'h02
`define RIMG_OFS_CTRL   8'h03
// ==========================================================
// Mask register fields
`define RIMG_BIT_MIN_TICK    0
`define RIMG_BIT_ALARM1      1
`define RIMG_BIT_ALARM2      2
`define RIMG_BIT_UVR         3
`define RIMG_BIT_SEC_TICK    4
`define RIMG_MASK_W          5
`define RIMG_MASK_RST        5'h1F
// ==========================================================
// Gate and control register fields
`define RIMG_BIT_NUMFMT      0
`define RIMG_BIT_HRFMT       1
`define RIMG_GATE_RST        2'h3
`define RIMG_CTRL_RST        2'h0
`endif

/* File: hw/rimg_pkg.sv */
package rimg_pkg;
    // Register select decoded from the address
    typedef enum logic [1:0] {
        RIMG_SEL_NONE = 2'h0,
        RIMG_SEL_MASK = 2'h1,
        RIMG_SEL_GATE = 2'h3,
        RIMG_SEL_CTRL = 2'h2
    } rimg_sel_t;
endpackage

/* File: hw/rimg_top.sv */
// Behaviour
// - bit 4 masks one-second tick, resets masked
// - bit 1 masks first alarm, resets masked
// - hour-format writes need permit bit 1
// - gate bit 0 permits number-format, resets 1
// - number-format writes ignored while permit 0
// - unbuilt upper bits store nothing, read zero
`timescale 1ns/1ps
`include "rimg_consts.svh"
module rimg_top (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    input  wire logic [4:0] EVT_FLAGS,
    output logic      [7:0] RDATA,
    output logic            IRQ_N,
    output logic            HOUR_FORMAT_SELECT,
    output logic            NUMBER_FORMAT_SELECT
);
    // ======================================================
    // Assertion clock and reset for the whole block
    default clocking cb_sys @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);

    // ======================================================
    // Address decode
    rimg_pkg::rimg_sel_t sel;   // Selected register
    assign sel = (ADDR == `RIMG_OFS_MASK) ? rimg_pkg::RIMG_SEL_MASK :
                 (ADDR == `RIMG_OFS_GATE) ? rimg_pkg::RIMG_SEL_GATE :
                 (ADDR == `RIMG_OFS_CTRL) ? rimg_pkg::RIMG_SEL_CTRL :
                 rimg_pkg::RIMG_SEL_NONE;

    logic [4:0] mask_q;          // Interrupt mask bits
    logic [1:0] gate_q;          // Write permits
    logic [1:0] ctrl_q;          // Hour and number format
    logic [1:0] ctrl_d;          // Next format value
    logic [7:0] rdata_q;         // Registered read data
    logic [7:0] rmux;            // Read mux
    logic       wr_mask;         // Write mask register
    logic       wr_gate;         // Write gate register
    logic       wr_ctrl;         // Write control register

    assign wr_mask = WR && (sel == rimg_pkg::RIMG_SEL_MASK);
    assign wr_gate = WR && (sel == rimg_pkg::RIMG_SEL_GATE);
    assign wr_ctrl = WR && (sel == rimg_pkg::RIMG_SEL_CTRL);

    // ======================================================
    // Permit-gated control bits
    assign ctrl_d[`RIMG_BIT_HRFMT] =
        (wr_ctrl && gate_q[`RIMG_BIT_HRFMT]) ?
        WDATA[`RIMG_BIT_HRFMT] : ctrl_q[`RIMG_BIT_HRFMT];
    assign ctrl_d[`RIMG_BIT_NUMFMT] =
        (wr_ctrl && gate_q[`RIMG_BIT_NUMFMT]) ?
        WDATA[`RIMG_BIT_NUMFMT] : ctrl_q[`RIMG_BIT_NUMFMT];

    // Mask register, resets all masked
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mask_q <= `RIMG_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= WDATA[4:0];
        end
    end

    // Gate register, resets permitting
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            gate_q <= `RIMG_GATE_RST;
        end else if (wr_gate) begin
            gate_q <= WDATA[1:0];
        end
    end

    // Control register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= `RIMG_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ======================================================
    // Read path, unbuilt bits read zero
    assign rmux = (sel == rimg_pkg::RIMG_SEL_MASK) ? {3'h0, mask_q} :
                  (sel == rimg_pkg::RIMG_SEL_GATE) ? {6'h00, gate_q} :
                  (sel == rimg_pkg::RIMG_SEL_CTRL) ? {6'h00, ctrl_q} :
                  8'h00;

    // Read data valid one cycle after strobe only
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= RD ? rmux : 8'h00;
        end
    end

    // ======================================================
    // Masked interrupt output, 1 in mask blocks a source
    // Each source passes through its own mask bit; a set bit
    // keeps that source off the shared interrupt line.
    logic [4:0] src_open;        // Sources pending and unmasked
    logic       irq_n_d;         // Next interrupt level

    // One gate per interrupt source
    genvar k;
    generate
        for (k = 0; k < `RIMG_MASK_W; k++) begin : g_src_gate
            // Pending and not masked opens this source
            assign src_open[k] = EVT_FLAGS[k] & ~mask_q[k];
        end
    endgenerate

    // Active low: any open source pulls the line low
    assign irq_n_d = ~|src_open;

    // Registered interrupt, so the pin never glitches
    logic irq_n_q; // Registered interrupt, active low
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= irq_n_d;
        end
    end

    // ======================================================
    // Outputs, all taken straight from flip-flops
    assign RDATA                = rdata_q;
    assign IRQ_N                = irq_n_q;
    assign HOUR_FORMAT_SELECT   = ctrl_q[`RIMG_BIT_HRFMT];
    assign NUMBER_FORMAT_SELECT = ctrl_q[`RIMG_BIT_NUMFMT];

    // ======================================================
    // Assertions: control permits
    // A closed hour permit leaves the hour format alone
    a_hour_locked: assert property (
        (wr_ctrl && !gate_q[1]) |=> $stable(ctrl_q[1]))
        else $error("hour format changed while locked");

    // An open hour permit lets the write through
    a_hour_write: assert property (
        (wr_ctrl && gate_q[1]) |=> ctrl_q[1] == $past(WDATA[1]))
        else $error("hour format write lost");

    // A closed number permit leaves the number format alone
    a_num_locked: assert property (
        (wr_ctrl && !gate_q[0]) |=> $stable(ctrl_q[0]))
        else $error("number format changed while locked");

    // An open number permit lets the write through
    a_num_write: assert property (
        (wr_ctrl && gate_q[0]) |=> ctrl_q[0] == $past(WDATA[0]))
        else $error("number format write lost");

    // Gate register takes a write on the next edge
    a_gate_write: assert property (
        wr_gate |=> gate_q == $past(WDATA[1:0]))
        else $error("gate register write lost");

    // ======================================================
    // Assertions: interrupt masking
    // A masked second tick alone never interrupts
    a_sec_masked: assert property (
        (EVT_FLAGS == 5'h10 && mask_q[4]) |=> IRQ_N)
        else $error("masked second tick raised interrupt");

    // An unmasked first alarm always interrupts
    a_alarm_open: assert property (
        (EVT_FLAGS[1] && !mask_q[1]) |=> !IRQ_N)
        else $error("unmasked alarm did not interrupt");

    // No open source means the line stays high
    a_other_mask: assert property (
        ((EVT_FLAGS & ~mask_q) == 5'h00) |=> IRQ_N)
        else $error("interrupt without unmasked source");

    // Mask register takes a write on the next edge
    a_mask_write: assert property (
        wr_mask |=> mask_q == $past(WDATA[4:0]))
        else $error("mask register write lost");

    // ======================================================
    // Assertions: register access
    // Mask readback stands in the cycle after the strobe
    a_mask_read: assert property (
        (RD && sel == rimg_pkg::RIMG_SEL_MASK) |=>
        RDATA == {3'h0, mask_q})
        else $error("mask readback wrong");

    // Gate readback stands in the cycle after the strobe
    a_gate_read: assert property (
        (RD && sel == rimg_pkg::RIMG_SEL_GATE) |=>
        RDATA == {6'h00, gate_q})
        else $error("gate readback wrong");

    // Unmapped places read as zero
    a_none_read: assert property (
        (RD && sel == rimg_pkg::RIMG_SEL_NONE) |=> RDATA == 8'h00)
        else $error("unmapped readback not zero");

    // Read data fall back to zero outside the read slot
    a_read_idle: assert property (
        !RD |=> RDATA == 8'h00)
        else $error("read data outside read slot");

    // ======================================================
    // Cover points for the main scenarios
    c_lock_write: cover property (wr_ctrl && !gate_q[1]);
    c_open_write: cover property (wr_ctrl && gate_q[0]);
    c_irq_fire: cover property (!IRQ_N);
    c_mask_open: cover property (wr_mask && WDATA[4:0] == 5'h00);
    c_gate_read: cover property (RD && sel == rimg_pkg::RIMG_SEL_GATE);
endmodule // rimg_top

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "rimg_consts.svh"
module tb;
    logic       CLK_SYS, RST_N, WR, RD, IRQ_N;
    logic       HOUR_FORMAT_SELECT, NUMBER_FORMAT_SELECT;
    logic [7:0] ADDR, WDATA, RDATA, a, d;
    logic [4:0] EVT_FLAGS, m; // Flags driven, mask model
    logic [1:0] g, c;         // Gate and control model
    integer     err_total, samples_checked, seed, i;
    rimg_top i_rimg_top (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .EVT_FLAGS(EVT_FLAGS),
        .RDATA(RDATA), .IRQ_N(IRQ_N),
        .HOUR_FORMAT_SELECT(HOUR_FORMAT_SELECT),
        .NUMBER_FORMAT_SELECT(NUMBER_FORMAT_SELECT));
    // ==========================================
    // Clock and helpers
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Expected readback of one address
    function logic [7:0] exp_rd(input logic [7:0] ad);
        case (ad)
            `RIMG_OFS_MASK: return {3'h0, m};
            `RIMG_OFS_GATE: return {6'h00, g};
            `RIMG_OFS_CTRL: return {6'h00, c};
            default:        return 8'h00;
        endcase
    endfunction
    // Write cycle, then model update
    task wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge CLK_SYS);
        WR <= 1'b1; ADDR <= ad; WDATA <= dt;
        @(posedge CLK_SYS);
        WR <= 1'b0;
        if (ad == `RIMG_OFS_MASK) m = dt[4:0];
        if (ad == `RIMG_OFS_GATE) g = dt[1:0];
        if (ad == `RIMG_OFS_CTRL) c = (dt[1:0] & g) | (c & ~g);
    endtask
    task rd(input logic [7:0] ad);
        @(posedge CLK_SYS);
        RD <= 1'b1; ADDR <= ad;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 chk(RDATA, exp_rd(ad));
    endtask
    // Outputs after two settled edges
    task outs;
        repeat (2) @(posedge CLK_SYS);
        #1 chk({7'h00, IRQ_N}, {7'h00, ~|(EVT_FLAGS & ~m)});
        chk({6'h00, HOUR_FORMAT_SELECT, NUMBER_FORMAT_SELECT}, {6'h00, c});
        chk(RDATA, 8'h00);
    endtask
    task wrap_up;
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Watchdog
    initial begin
        #(5000 * 100);
        err_total++;
        wrap_up();
    end
    // ==========================================
    // Main sequence
    initial begin
        {RST_N, WR, RD, ADDR, WDATA} = '0;
        EVT_FLAGS = 5'h1F; seed = 9054; err_total = 0; samples_checked = 0;
        m = `RIMG_MASK_RST; g = `RIMG_GATE_RST; c = `RIMG_CTRL_RST;
        repeat (20) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        for (i = 0; i < 5; i++) rd(i[7:0]);
        outs();
        // Each mask bit against its own source
        for (i = 0; i < 5; i++) begin
            wr(`RIMG_OFS_MASK, 8'h1F ^ (8'h01 << i));
            EVT_FLAGS <= 5'h01 << i;
            outs();
            EVT_FLAGS <= 5'h1F ^ (5'h01 << i);
            outs();
        end
        // Permits closed, then each one alone, then both open
        for (i = 0; i < 4; i++) begin
            wr(`RIMG_OFS_GATE, i[7:0]);
            wr(`RIMG_OFS_CTRL, {6'h00, ~c});
            rd(`RIMG_OFS_CTRL);
            outs();
        end
        // Random traffic, unmapped places included
        for (i = 0; i < 300; i++) begin
            a = 8'($unsigned($random(seed)) % 5);
            d = 8'($random(seed));
            if (a == `RIMG_OFS_MASK) d = d & 8'h1F;
            else if (a != 8'h00 && a != 8'h04) d = d & 8'h03;
            EVT_FLAGS <= 5'($random(seed));
            wr(a, d);
            rd(8'($unsigned($random(seed)) % 5));
            outs();
        end
        // Reset again mid-run, all registers back to reset values
        @(posedge CLK_SYS);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        m = `RIMG_MASK_RST; g = `RIMG_GATE_RST; c = `RIMG_CTRL_RST;
        RST_N <= 1'b1;
        for (i = 0; i < 5; i++) rd(i[7:0]);
        outs();
        wrap_up();
    end
endmodule // tb
